// >>> include/emuart_pkg.sv
`default_nettype none
// ============================================================
// Shared constants for the eight channel multiplexed serial block.
package emuart_pkg;

  // ============================================================
  // Channel and service slot layout.
  localparam int NUM_CH = 8;
  localparam int CH_PER_SLOT = 2;
  localparam int NUM_SLOTS = NUM_CH / CH_PER_SLOT;
  localparam int SEL_W = 8;
  localparam logic [SEL_W-1:0] SEL_RELOAD = 8'hff;
  localparam logic [SEL_W-1:0] LAST_SLOT = 8'(NUM_SLOTS - 1);

  // ============================================================
  // Timing: the tick runs at the sample rate of the lines.
  localparam int CLK_HZ = 100_000_000;
  localparam int SAMPLE_RATE_HZ = 230_400;
  localparam int TICK_CYCLES_DEF = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int TICK_W = 16;
  localparam int BAUD_DEF_BPS = 57_600;
  localparam int SLOT_RUNS = NUM_SLOTS;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_DEF =
    8'(SAMPLE_RATE_HZ / (BAUD_DEF_BPS * SLOT_RUNS));
  // Start delay is three halves of the bit divide ratio, rounded down, in service passes.
  localparam int ST_NUM = 3;
  localparam int ST_DEN = 2;
  localparam logic [DIV_W-1:0] STDELAY_DEF =
    8'((ST_NUM * int'(DIV_DEF)) / ST_DEN);
  localparam logic [DIV_W-1:0] DIV_EXPIRE = 8'h01;

  // ============================================================
  // Frame shape: start, eight data bits, stop.
  localparam logic [3:0] TX_BITS = 4'ha;
  localparam logic [3:0] RX_BITS = 4'h9;
  localparam logic [3:0] CNT_LAST = 4'h1;
  localparam logic [3:0] CNT_IDLE = 4'h0;

  // ============================================================
  // Register map: per channel block of eight bytes, then flags.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [2:0] REG_TXDATA = 3'h0;
  localparam logic [2:0] REG_RXDATA = 3'h1;
  localparam logic [2:0] REG_DIVIDE = 3'h2;
  localparam logic [2:0] REG_STDELAY = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_TXPEND = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_RXFULL = 8'h41;
  localparam logic [1:0] CH_AREA = 2'h0;

endpackage : emuart_pkg
`default_nettype wire

// >>> hdl/emuart_tx_lane.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// One transmit lane, advanced only on its service pulses.
module emuart_tx_lane
  import emuart_pkg::*;
(
  input wire logic core_clk,               // System clock.
  input wire logic reset,                  // Synchronous reset.
  input wire logic svc,                    // Service pass for this lane.
  input wire logic pend,                   // Transmit pending flag.
  input wire logic [7:0] data,             // Byte to send.
  input wire logic [DIV_W-1:0] ratio,      // Bit divide ratio.
  output logic txd,                        // Serial output line.
  output logic done                        // Frame finished pulse.
);

  logic [3:0] cnt_r;
  logic [DIV_W-1:0] div_r;
  logic [8:0] sh_r;
  logic txd_r;
  wire expire = (div_r <= DIV_EXPIRE);

  // Frame ends as the stop bit is put on the line.
  assign done = svc && (cnt_r == CNT_LAST) && expire;
  assign txd = txd_r;

  // Shift out LSB first, one bit per divide expiry.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= CNT_IDLE;
      div_r <= DIV_EXPIRE;
      sh_r <= '1;
      txd_r <= 1'b1;
    end else if (svc) begin
      if (cnt_r != CNT_IDLE) begin
        if (expire) begin
          div_r <= ratio;
          txd_r <= sh_r[0];
          sh_r <= {1'b1, sh_r[8:1]};
          cnt_r <= cnt_r - 4'h1;
        end else begin
          div_r <= div_r - 8'h01;
        end
      end else if (pend) begin
        sh_r <= {data, 1'b0};
        cnt_r <= TX_BITS;
        div_r <= ratio;
      end
    end
  end

  // Between expiries the line holds its level.
  property p_tx_hold;
    @(posedge core_clk) disable iff (reset)
      !(svc && expire && cnt_r != CNT_IDLE) |=> $stable(txd);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx line moved without divide expiry");

endmodule : emuart_tx_lane
`default_nettype wire

// >>> hdl/emuart_rx_lane.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// One receive lane with pin synchroniser and bit sampler.
module emuart_rx_lane
  import emuart_pkg::*;
(
  input wire logic core_clk,               // System clock.
  input wire logic reset,                  // Synchronous reset.
  input wire logic svc,                    // Service pass for this lane.
  input wire logic rxd,                    // Serial input pin.
  input wire logic [DIV_W-1:0] ratio,      // Bit divide ratio.
  input wire logic [DIV_W-1:0] stdelay,    // Start sample delay.
  output logic [7:0] data,                 // Last received byte.
  output logic done                        // Byte assembled pulse.
);

  logic s1_r, s2_r, s3_r, lvl_r;
  logic [3:0] cnt_r;
  logic [DIV_W-1:0] div_r;
  logic [7:0] buf_r;
  logic [7:0] data_r;
  wire expire = (div_r <= DIV_EXPIRE);

  assign done = svc && (cnt_r == CNT_LAST) && expire;
  assign data = data_r;

  // Three stage synchroniser; the level follows once stages two
  // and three agree.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      lvl_r <= 1'b1;
    end else begin
      s1_r <= rxd;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) lvl_r <= s3_r;
    end
  end

  // Start detect only from idle, then sample each expiry.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= CNT_IDLE;
      div_r <= DIV_EXPIRE;
      buf_r <= '0;
      data_r <= '0;
    end else if (svc) begin
      if (cnt_r == CNT_IDLE) begin
        if (!lvl_r) begin
          cnt_r <= RX_BITS;
          div_r <= stdelay;
        end
      end else if (expire) begin
        div_r <= ratio;
        buf_r <= {lvl_r, buf_r[7:1]};
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == CNT_LAST) data_r <= buf_r;
      end else begin
        div_r <= div_r - 8'h01;
      end
    end
  end

  property p_rx_load;
    @(posedge core_clk) disable iff (reset)
      svc && cnt_r == CNT_IDLE && !lvl_r
      |=> cnt_r == RX_BITS && div_r == $past(stdelay);
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("start bit did not load counters");

  property p_rx_reload;
    @(posedge core_clk) disable iff (reset)
      svc && cnt_r != CNT_IDLE && expire
      |=> div_r == $past(ratio) && buf_r[7] == $past(lvl_r);
  endproperty
  a_rx_reload: assert property (p_rx_reload)
    else $error("expiry did not reload divide or shift sample");

endmodule : emuart_rx_lane
`default_nettype wire

// >>> hdl/emuart_top.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
module emuart_top
  import emuart_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF  // Clocks per tick.
)(
  input wire logic core_clk,                 // System clock, 100 MHz.
  input wire logic reset,                    // Synchronous reset.
  input wire logic [ADDR_W-1:0] reg_addr,    // Register address.
  input wire logic [DATA_W-1:0] reg_wdata,   // Register write data.
  input wire logic reg_wr,                   // Write strobe.
  input wire logic reg_rd,                   // Read strobe.
  output logic [DATA_W-1:0] reg_rdata,       // Read data, next cycle.
  output logic [NUM_CH-1:0] tx_line,         // Transmit lines.
  input wire logic [NUM_CH-1:0] rx_line,     // Receive lines.
  output logic [SEL_W-1:0] service_slot      // Slot run on last tick.
);

  localparam logic [TICK_W-1:0] TICK_RELOAD = TICK_W'(-TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_FIRE = '1;

  // ============================================================
  // Address decoding helpers.

  // True when the address selects the given register in a channel's block.
  function automatic logic ch_hit(input logic [ADDR_W-1:0] a,
                                  input logic [2:0] reg_sel);
    ch_hit = (a[7:6] == CH_AREA) && (a[2:0] == reg_sel);
  endfunction : ch_hit

  // Channel number carried in a channel block address.
  function automatic logic [2:0] ch_of(input logic [ADDR_W-1:0] a);
    ch_of = a[5:3];
  endfunction : ch_of

  // ============================================================
  // Storage.
  logic [TICK_W-1:0] tick_counter_r;
  logic [SEL_W-1:0] slot_selector_r;
  logic [SEL_W-1:0] service_slot_r;
  logic [7:0] tx_data_r [NUM_CH];
  logic [DIV_W-1:0] bit_divide_ratio_r [NUM_CH];
  logic [DIV_W-1:0] start_sample_delay_r [NUM_CH];
  logic [NUM_CH-1:0] tx_pending_flag_r;
  logic [NUM_CH-1:0] rx_full_r;
  logic [DATA_W-1:0] rdata_r;

  logic [NUM_CH-1:0] svc;
  logic [NUM_CH-1:0] tx_done;
  logic [NUM_CH-1:0] rx_done;
  logic [7:0] rx_data [NUM_CH];

  // ============================================================
  // Tick generation and slot rotation.

  // The tick fires when the counter reaches all ones.
  wire tick = (tick_counter_r == TICK_FIRE);
  wire [SEL_W-1:0] sel_inc = slot_selector_r + 8'h01;
  wire last_slot = (sel_inc == LAST_SLOT);
  wire [SEL_W-1:0] slot_selector_nxt =
    last_slot ? SEL_RELOAD : sel_inc;

  // Counter reload makes the tick period independent of work.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tick_counter_r <= TICK_RELOAD;
    end else if (tick) begin
      tick_counter_r <= TICK_RELOAD;
    end else begin
      tick_counter_r <= tick_counter_r + 16'h0001;
    end
  end

  // The selector starts at its reload value so slot zero runs first.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      slot_selector_r <= SEL_RELOAD;
      service_slot_r <= SEL_RELOAD;
    end else if (tick) begin
      slot_selector_r <= slot_selector_nxt;
      service_slot_r <= sel_inc;
    end
  end

  assign service_slot = service_slot_r;

  // Each slot serves channels 2s and 2s+1 on its tick.
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_svc
      assign svc[gc] =
        tick && (sel_inc == SEL_W'(gc / CH_PER_SLOT));
    end
  endgenerate

  // ============================================================
  // Channel lanes.

  // Every channel has its own ratio and delay, so rates can differ.
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      emuart_tx_lane u_tx (
        .core_clk (core_clk),
        .reset (reset),
        .svc (svc[gc]),
        .pend (tx_pending_flag_r[gc]),
        .data (tx_data_r[gc]),
        .ratio (bit_divide_ratio_r[gc]),
        .txd (tx_line[gc]),
        .done (tx_done[gc])
      );
      emuart_rx_lane u_rx (
        .core_clk (core_clk),
        .reset (reset),
        .svc (svc[gc]),
        .rxd (rx_line[gc]),
        .ratio (bit_divide_ratio_r[gc]),
        .stdelay (start_sample_delay_r[gc]),
        .data (rx_data[gc]),
        .done (rx_done[gc])
      );
    end
  endgenerate

  // ============================================================
  // Register writes.

  // Write strobes decoded per register kind.
  wire wr_txdata = reg_wr && ch_hit(reg_addr, REG_TXDATA);
  wire wr_divide = reg_wr && ch_hit(reg_addr, REG_DIVIDE);
  wire wr_stdelay = reg_wr && ch_hit(reg_addr, REG_STDELAY);
  wire wr_txpend = reg_wr && (reg_addr == ADDR_TXPEND);
  wire rd_rxdata = reg_rd && ch_hit(reg_addr, REG_RXDATA);
  wire [2:0] acc_ch = ch_of(reg_addr);

  // Per channel data and rate settings; defaults give 57600 bit/s.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        tx_data_r[i] <= '0;
        bit_divide_ratio_r[i] <= DIV_DEF;
        start_sample_delay_r[i] <= STDELAY_DEF;
      end
    end else begin
      if (wr_txdata) tx_data_r[acc_ch] <= reg_wdata;
      if (wr_divide) bit_divide_ratio_r[acc_ch] <= reg_wdata;
      if (wr_stdelay) start_sample_delay_r[acc_ch] <= reg_wdata;
    end
  end

  // ============================================================
  // Flags: software sets pending, hardware clears it at frame end;
  // hardware sets receive full, a data read clears it. A set always
  // wins over a clear in the same cycle.

  // One-hot mask of the channel whose receive data is being read.
  wire [NUM_CH-1:0] rd_clr = rd_rxdata ? (8'h01 << acc_ch) : 8'h00;
  wire [NUM_CH-1:0] pend_set = wr_txpend ? reg_wdata : 8'h00;
  wire [NUM_CH-1:0] tx_pending_flag_nxt =
    (tx_pending_flag_r & ~tx_done) | pend_set;
  wire [NUM_CH-1:0] rx_full_nxt = (rx_full_r & ~rd_clr) | rx_done;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_pending_flag_r <= '0;
      rx_full_r <= '0;
    end else begin
      tx_pending_flag_r <= tx_pending_flag_nxt;
      rx_full_r <= rx_full_nxt;
    end
  end

  // ============================================================
  // Register reads: data stands one cycle after the strobe only.

  // Selected read value; unmapped addresses read as zero.
  wire [DATA_W-1:0] rd_word =
    ch_hit(reg_addr, REG_TXDATA) ? tx_data_r[acc_ch] :
    ch_hit(reg_addr, REG_RXDATA) ? rx_data[acc_ch] :
    ch_hit(reg_addr, REG_DIVIDE) ? bit_divide_ratio_r[acc_ch] :
    ch_hit(reg_addr, REG_STDELAY) ? start_sample_delay_r[acc_ch] :
    (reg_addr == ADDR_TXPEND) ? tx_pending_flag_r :
    (reg_addr == ADDR_RXFULL) ? rx_full_r : 8'h00;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_word : 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  // ============================================================
  // Checks.

  property p_slot_pair;
    @(posedge core_clk) disable iff (reset)
      tick |-> $countones(svc) == CH_PER_SLOT;
  endproperty
  a_slot_pair: assert property (p_slot_pair)
    else $error("a tick did not serve exactly two channels");

  property p_no_idle_svc;
    @(posedge core_clk) disable iff (reset)
      !tick |-> svc == '0;
  endproperty
  a_no_idle_svc: assert property (p_no_idle_svc)
    else $error("channel served without a tick");

  property p_slot_wrap;
    @(posedge core_clk) disable iff (reset)
      tick && service_slot_r == (LAST_SLOT - 8'h01)
      |=> slot_selector_r == SEL_RELOAD && service_slot_r == LAST_SLOT;
  endproperty
  a_slot_wrap: assert property (p_slot_wrap)
    else $error("last slot did not reload the selector");

  property p_tick_reload;
    @(posedge core_clk) disable iff (reset)
      tick |=> tick_counter_r == TICK_RELOAD;
  endproperty
  a_tick_reload: assert property (p_tick_reload)
    else $error("tick counter not reloaded after tick");

  property p_tick_gap;
    @(posedge core_clk) disable iff (reset)
      tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("ticks too close together");

  property p_div_write;
    @(posedge core_clk) disable iff (reset)
      wr_divide |=> bit_divide_ratio_r[$past(acc_ch)] == $past(reg_wdata);
  endproperty
  a_div_write: assert property (p_div_write)
    else $error("divide ratio write not stored");

  property p_rx_flag;
    @(posedge core_clk) disable iff (reset)
      rx_done != '0 |=> (rx_full_r & $past(rx_done)) == $past(rx_done);
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("receive flag not set on assembled byte");

  property p_tx_clear;
    @(posedge core_clk) disable iff (reset)
      tx_done[0] && !(wr_txpend && reg_wdata[0])
      |=> !tx_pending_flag_r[0];
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("pending flag not cleared at frame end");

  property p_rdata_idle;
    @(posedge core_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");

  property p_slot_step;
    @(posedge core_clk) disable iff (reset)
      tick |=> service_slot_r == $past(sel_inc);
  endproperty
  a_slot_step: assert property (p_slot_step)
    else $error("service slot did not advance on tick");

  property p_tick_count;
    @(posedge core_clk) disable iff (reset)
      !tick |=> tick_counter_r == $past(tick_counter_r) + 16'h0001;
  endproperty
  a_tick_count: assert property (p_tick_count)
    else $error("tick counter did not count between ticks");

  property p_pend_set;
    @(posedge core_clk) disable iff (reset)
      wr_txpend |=> (tx_pending_flag_r & $past(pend_set)) == $past(pend_set);
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("pending flag write did not set bits");

  property p_rd_clear;
    @(posedge core_clk) disable iff (reset)
      rd_rxdata && rx_done == '0 |=> !rx_full_r[$past(acc_ch)];
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("receive flag not cleared by data read");

endmodule : emuart_top
`default_nettype wire

// >>> bench/emuart_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Serial peers: one frame sender and one frame catcher per channel.
module emuart_peer
  import emuart_pkg::*;
(
  input wire logic core_clk,             // System clock.
  input wire logic [NUM_CH-1:0] tx_line, // Lines from the block.
  output logic [NUM_CH-1:0] rx_line      // Lines to the block.
);
  int per_clk [NUM_CH];
  logic [7:0] send_b [NUM_CH];
  logic [7:0] got_byte [NUM_CH];
  logic got_stop [NUM_CH];
  int got_len [NUM_CH];
  int got_n [NUM_CH];
  event go;

  // Idle lines rest at the mark level until a frame is sent.
  initial begin
    rx_line = '1;
    for (int c = 0; c < NUM_CH; c++) begin
      per_clk[c] = 64;
      got_n[c] = 0;
    end
  end

  // Each channel sends on demand and times and samples what it hears.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    always begin : send_frame
      logic [9:0] f;
      @(go);
      f = {1'b1, send_b[g], 1'b0};
      for (int i = 0; i < 10; i++) begin
        rx_line[g] <= f[i];
        repeat (per_clk[g]) @(posedge core_clk);
      end
    end
    // Timing runs from the start edge, so low data bits after the start
    // bit neither stretch the sample points nor hide the first rise.
    always begin : catch_frame
      int t;
      int h;
      logic [8:0] sh;
      @(negedge tx_line[g]);
      t = 0;
      h = per_clk[g] / 2;
      for (int k = 1; k <= 9 * per_clk[g] + h; k++) begin
        @(posedge core_clk);
        #1;
        if (t == 0 && tx_line[g] !== 1'b0) t = k;
        if (k > per_clk[g] && (k - h) % per_clk[g] == 0) begin
          sh = {tx_line[g], sh[8:1]};
        end
      end
      got_len[g] = t;
      got_byte[g] = sh[7:0];
      got_stop[g] = sh[8];
      got_n[g]++;
    end
  end
endmodule : emuart_peer
`default_nettype wire

// >>> bench/tb_emuart_top.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Self-checking bench for the eight channel serial block.
module tb_emuart_top
  import emuart_pkg::*;
();
  localparam int TICK = 16;
  localparam int PASS = TICK * NUM_SLOTS;
  logic core_clk, reset, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [NUM_CH-1:0] tx_line, rx_line;
  logic [SEL_W-1:0] service_slot, last_slot;
  int n_errors, num_checks, seed, last_t, cyc;
  logic [7:0] ratio [NUM_CH];
  logic [7:0] tx_b [NUM_CH];
  int base_n [NUM_CH];

  emuart_top #(.TICK_CYCLES(TICK)) uut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_line(tx_line), .rx_line(rx_line),
    .service_slot(service_slot));

  emuart_peer peer (.core_clk(core_clk), .tx_line(tx_line),
    .rx_line(rx_line));

  // ============================================================
  // Helpers for the register port and for comparisons.
  function automatic logic [7:0] addr(input int c, input logic [2:0] o);
    return 8'(c * 8 + int'(o));
  endfunction : addr

  function automatic bit all_got();
    for (int c = 0; c < NUM_CH; c++) begin
      if (peer.got_n[c] == base_n[c]) return 1'b0;
    end
    return 1'b1;
  endfunction : all_got

  // Bit periods from the start edge to the first rise of the line.
  function automatic int low_bits(input logic [7:0] b);
    int n;
    n = 1;
    while (n < 9 && !b[n-1]) n++;
    return n;
  endfunction : low_bits

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input string what);
    logic [7:0] v;
    rd(a, v);
    chk(16'(v), 16'(e), what);
  endtask : rdc

  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // Free running clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Checks that slots rotate in order at a fixed tick spacing.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (reset) begin
      last_slot <= SEL_RELOAD;
      last_t <= -1;
    end else if (service_slot !== last_slot) begin
      chk(16'(service_slot), 16'(last_slot == LAST_SLOT ? 8'h00 :
          8'(last_slot + 8'h01)), "slot");
      if (last_t >= 0) chk(16'(cyc - last_t), 16'(TICK), "tick");
      last_t <= cyc;
      last_slot <= service_slot;
    end
  end

  // ============================================================
  // Main sequence: reset values, transmit on all, receive on all.
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    n_errors = 0;
    num_checks = 0;
    seed = 110;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    chk(16'(tx_line), 16'h00ff, "idle");
    rdc(addr(0, REG_DIVIDE), DIV_DEF, "div0");
    rdc(addr(7, REG_STDELAY), STDELAY_DEF, "std0");
    @(posedge core_clk);
    #1;
    chk(16'(reg_rdata), 16'h0000, "stand");
    wr(8'h7f, 8'h5a);
    rdc(8'h7f, 8'h00, "unmapped");
    for (int c = 0; c < NUM_CH; c++) begin
      ratio[c] = 8'(4 + ($random(seed) & 3));
      tx_b[c] = c == 0 ? 8'h00 : c == 1 ? 8'hff : 8'($random(seed));
      peer.per_clk[c] = int'(ratio[c]) * PASS;
      base_n[c] = peer.got_n[c];
      wr(addr(c, REG_DIVIDE), ratio[c]);
      wr(addr(c, REG_STDELAY), 8'(int'(ratio[c]) * 3 / 2));
      wr(addr(c, REG_TXDATA), tx_b[c]);
      rdc(addr(c, REG_DIVIDE), ratio[c], "div");
      rdc(addr(c, REG_STDELAY), 8'(int'(ratio[c]) * 3 / 2), "std");
      rdc(addr(c, REG_TXDATA), tx_b[c], "txd");
    end
    rdc(ADDR_TXPEND, 8'h00, "pend idle");
    wr(ADDR_TXPEND, 8'hff);
    for (int k = 0; k < 8000 && !all_got(); k++) @(posedge core_clk);
    for (int c = 0; c < NUM_CH; c++) begin
      chk(16'(peer.got_byte[c]), 16'(tx_b[c]), "tx byte");
      chk(16'(peer.got_stop[c]), 16'h0001, "tx stop");
      chk(16'(peer.got_len[c]),
          16'(low_bits(tx_b[c]) * peer.per_clk[c]), "bit len");
    end
    repeat (PASS) @(posedge core_clk);
    rdc(ADDR_TXPEND, 8'h00, "pend done");
    rdc(ADDR_RXFULL, 8'h00, "rx empty");
    for (int c = 0; c < NUM_CH; c++) begin
      tx_b[c] = c == 0 ? 8'hff : c == 1 ? 8'h00 : 8'($random(seed));
      peer.send_b[c] = tx_b[c];
    end
    @(posedge core_clk);
    -> peer.go;
    d = 8'h00;
    for (int k = 0; k < 4000 && d !== 8'hff; k++) rd(ADDR_RXFULL, d);
    chk(16'(d), 16'h00ff, "rx full");
    for (int c = 0; c < NUM_CH; c++) begin
      rdc(addr(c, REG_RXDATA), tx_b[c], "rx byte");
    end
    rdc(ADDR_RXFULL, 8'h00, "rx cleared");
    summarize();
  end

  // Cuts a hung run short.
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    summarize();
  end
endmodule : tb_emuart_top
`default_nettype wire
